// ---- hdl/order_decode_pkg.sv ----
// Constants and types for the order code decoder
package order_decode_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          CYC_PER_US  = CLK_HZ / 1_000_000;
  localparam int          CNT_W       = 24;
  localparam logic [23:0] CYC_US      = 24'(CYC_PER_US);
  localparam logic [5:0]  T_LIT_US    = 6'h04;
  localparam logic [5:0]  T_MEM_US    = 6'h08;
  localparam logic [5:0]  T_STORE_US  = 6'h0c;
  localparam logic [5:0]  T_HIT_US    = 6'h10;
  localparam logic [5:0]  T_MISS_US   = 6'h0c;
  localparam logic [5:0]  T_STEP_US   = 6'h08;
  localparam logic [5:0]  T_MUL_US    = 6'h1c;
  localparam logic [5:0]  T_DIV_US    = 6'h33;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0]  A_ORDER     = 8'h00;
  localparam logic [7:0]  A_OUTCOME   = 8'h04;
  localparam logic [7:0]  A_SRCH_LEN  = 8'h08;
  localparam logic [7:0]  A_INDIRECT  = 8'h0c;
  localparam logic [7:0]  A_STATUS    = 8'h10;
  localparam logic [7:0]  A_INDEX     = 8'h14;
  localparam logic [7:0]  A_MODULE    = 8'h18;
  localparam logic [7:0]  A_CYCLES    = 8'h1c;
  // ****************************************
  // Word fields
  // ****************************************
  localparam int F_PAR  = 24;
  localparam int F_OP   = 18;
  localparam int F_PX   = 15;
  localparam int F_IND  = 14;
  localparam int F_REP  = 13;
  localparam int F_MSEL = 12;
  localparam int F_MV   = 9;
  localparam int F_MORE = 15;
  localparam logic [15:0] SRCH_LEN_RST = 16'h0001;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    C_NOP = 4'h0, C_ARITH = 4'h1, C_SEARCH = 4'h2, C_TEST = 4'h3,
    C_LOGIC = 4'h4, C_INDEX = 4'h5, C_STORE = 4'h6, C_DPREC = 4'h7,
    C_MULDIV = 4'h8, C_LOAD = 4'h9, C_BRANCH = 4'ha, C_ACCESS = 4'hb,
    C_IO = 4'hc
  } class_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_IND = 2'b01, S_EXEC = 2'b10
  } state_t;
endpackage

// ---- hdl/order_code_decoder.sv ----
// Order code decoder and sequencer with an AXI4-Lite register port
// Notes on behaviour
// [RQ1] Order 70 adds memory to A or C and stores back, 12 us.
// [RQ2] Order 71 subtracts memory from A or C and stores back, 12 us.
// [RQ3] Order 61 equality block search: 16+8(m-1) us hit, 12+8(m-1) miss.
// [RQ4] Orders 65 and 64 search greater or less, same timing.
// [RQ5] Search hit loads index with address, sets jump flag; miss clears it.
// [RQ6] Orders 01, 05, 04 compare register with literal in 4 us.
// [RQ7] Orders 21, 25, 24 compare register with memory in 8 us.
// [RQ8] Orders 35 and 34 clear or set bits from memory, 8 us.
// [RQ9] Orders 15 and 14 clear or set bits from literal, 4 us.
// [RQ10] Order 75 ANDs memory with register and stores back, 12 us.
// [RQ11] Order 63 tests or modifies memory index word, 12 us.
// [RQ12] Order 45 stores A, C or zeros in 8 us.
// [RQ13] Double precision 72, 73, 76, 55 take 12 us each.
// [RQ14] Multiply 33 takes 28 us, divide 32 takes 51 us.
// [RQ15] Orders 36, 37, 40 load or store registers in 8 us.
// [RQ16] Branches 03 and 02 take 4 us, 27 takes 8 us.
// [RQ17] Order 67 exchanges access controls in 12 us, 41 stores in 8.
// [RQ18] I/O orders 06, 07, 26 take 4 us; 22, 66 take 8 us.
// [RQ19] Indirect words carry 15-bit addresses, repeated for all levels.
// [RQ20] Memory select bit picks primary on 0, secondary on 1.
// [RQ21] Replace option substitutes word's module designator first.
// [RQ22] Words are 24 bits plus parity, one synchronous clock.
// [RQ23] Order code is six bits, sequenced for its cycle count.
// [RQ24] Unlisted orders act as 4 us no-operations; the code times unlisted orders 30 and 31 at 8 us.
`timescale 1ns/1ns
module order_code_decoder
  import order_decode_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // AXI4-Lite write
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  // Condition pins
  input  wire logic        EXT_JUMP,
  input  wire logic        PROG_CTL,
  // Access state
  output logic             ORDER_BUSY,
  output logic             MEM_SECONDARY,
  output logic [2:0]       MEM_MODULE,
  output logic [14:0]      ACCESS_ADDR
);
  // ****************************************
  // Decode functions
  // ****************************************
  function automatic class_t order_class(input logic [5:0] op);
    unique case (op)
      6'o70, 6'o71, 6'o30, 6'o31,
      6'o10, 6'o11:               order_class = C_ARITH;
      6'o61, 6'o65, 6'o64:        order_class = C_SEARCH;
      6'o01, 6'o05, 6'o04,
      6'o21, 6'o25, 6'o24:        order_class = C_TEST;
      6'o35, 6'o34, 6'o15,
      6'o14, 6'o75:               order_class = C_LOGIC;
      6'o63, 6'o77:               order_class = C_INDEX;
      6'o45, 6'o40:               order_class = C_STORE;
      6'o72, 6'o73, 6'o76, 6'o55: order_class = C_DPREC;
      6'o33, 6'o32:               order_class = C_MULDIV;
      6'o36, 6'o37:               order_class = C_LOAD;
      6'o03, 6'o02, 6'o27:        order_class = C_BRANCH;
      6'o67, 6'o41:               order_class = C_ACCESS;
      6'o06, 6'o07, 6'o22,
      6'o66, 6'o26:               order_class = C_IO;
      default:                    order_class = C_NOP;
    endcase
  endfunction

  function automatic logic [5:0] order_us(input logic [5:0] op);
    unique case (op)
      6'o70, 6'o71:               order_us = T_STORE_US; // RQ1 RQ2
      6'o01, 6'o05, 6'o04:        order_us = T_LIT_US;   // RQ6
      6'o21, 6'o25, 6'o24:        order_us = T_MEM_US;   // RQ7
      6'o35, 6'o34:               order_us = T_MEM_US;   // RQ8
      6'o15, 6'o14:               order_us = T_LIT_US;   // RQ9
      6'o75:                      order_us = T_STORE_US; // RQ10
      6'o63, 6'o77:               order_us = T_STORE_US; // RQ11
      6'o45:                      order_us = T_MEM_US;   // RQ12
      6'o72, 6'o73, 6'o76, 6'o55: order_us = T_STORE_US; // RQ13
      6'o33:                      order_us = T_MUL_US;   // RQ14
      6'o32:                      order_us = T_DIV_US;   // RQ14
      6'o36, 6'o37, 6'o40:        order_us = T_MEM_US;   // RQ15
      6'o03, 6'o02:               order_us = T_LIT_US;   // RQ16
      6'o27:                      order_us = T_MEM_US;   // RQ16
      6'o67:                      order_us = T_STORE_US; // RQ17
      6'o41:                      order_us = T_MEM_US;   // RQ17
      6'o06, 6'o07, 6'o26:        order_us = T_LIT_US;   // RQ18
      6'o22, 6'o66:               order_us = T_MEM_US;   // RQ18
      6'o30, 6'o31:               order_us = T_MEM_US;
      default:                    order_us = T_LIT_US;   // RQ24
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  state_t             state_q;
  logic [24:0]        word_q;
  logic [15:0]        outcome_q;
  logic [15:0]        srch_len_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   exec_len_q;
  logic [14:0]        index_q;
  logic [2:0]         prim_mod_q;
  logic [2:0]         sec_mod_q;
  logic               ijf_q;
  logic               taken_q;
  logic               par_err_q;
  logic [1:0][2:0]    sync_q;
  logic [1:0]         pin_q;
  logic               aw_hold_q;
  logic               w_hold_q;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic [1:0]         bresp_d;
  logic               wr_go;
  logic [31:0]        wval;
  logic [31:0]        rd_d;
  logic               rd_hit;
  logic               start;
  logic               go_exec;
  logic               fin;
  logic [5:0]         op;
  class_t             cls;
  logic [19:0]        exec_us;
  logic [CNT_W-1:0]   exec_cyc;
  logic               cond;
  logic [31:0]        order_w;
  logic [5:0]         exec_op;

  assign op      = word_q[F_OP +: 6];  // RQ23
  assign cls     = order_class(op);
  // New order is timed from the word being written, not the last one
  assign order_w = merge({7'h0, word_q}, wdata_q, wstrb_q);
  assign exec_op = state_q == S_IDLE ? order_w[F_OP +: 6] : op; // RQ23
  assign wr_go   = aw_hold_q && w_hold_q && !BVALID;
  assign start   = wr_go && awaddr_q == A_ORDER && state_q == S_IDLE;
  assign fin     = state_q == S_EXEC && cnt_q == '0;
  assign go_exec = wr_go && awaddr_q == A_INDIRECT && state_q == S_IND
                   && !wval[F_MORE];

  // ****************************************
  // Execution time
  // ****************************************
  always_comb begin
    exec_us = 20'(order_us(exec_op));
    if (order_class(exec_op) == C_SEARCH) begin
      // Timing needs the outcome first, so it is written before the order
      exec_us = 20'(outcome_q[15] ? T_HIT_US : T_MISS_US)
                + 20'(T_STEP_US) * 20'(srch_len_q - 16'h0001); // RQ3 RQ4
    end
    exec_cyc = CNT_W'(exec_us) * CYC_US; // RQ23
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        sync_q[i] <= 3'h0;
        pin_q[i]  <= 1'b0;
      end else begin
        sync_q[i] <= {sync_q[i][1:0], i == 0 ? EXT_JUMP : PROG_CTL};
        if (sync_q[i][1] == sync_q[i][2]) begin
          pin_q[i] <= sync_q[i][2];
        end
      end
    end
  end

  // ****************************************
  // AXI write channels
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      BVALID    <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= AWADDR;
        AWREADY   <= 1'b0;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
        AWREADY   <= 1'b1;
      end else begin
        AWREADY   <= !aw_hold_q;
      end
      if (WVALID && WREADY) begin
        w_hold_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
        WREADY   <= 1'b0;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
        WREADY   <= 1'b1;
      end else begin
        WREADY   <= !w_hold_q;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (awaddr_q)
      A_ORDER, A_OUTCOME, A_SRCH_LEN,
      A_INDIRECT, A_MODULE: bresp_d = RESP_OKAY;
      default:              bresp_d = RESP_SLVERR;
    endcase
    wval = merge(rd_d, wdata_q, wstrb_q);
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      BRESP <= RESP_OKAY;
    end else if (wr_go) begin
      BRESP <= bresp_d;
    end
  end

  // ****************************************
  // Software registers
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      word_q     <= 25'h0;
      outcome_q  <= 16'h0;
      srch_len_q <= SRCH_LEN_RST;
      par_err_q  <= 1'b0;
    end else if (wr_go) begin
      if (start) begin
        word_q    <= wval[24:0];
        // Odd parity over the word and its check bit
        par_err_q <= !(^wval[F_PAR:0]); // RQ22
      end
      if (awaddr_q == A_OUTCOME) begin
        outcome_q <= wval[15:0];
      end
      if (awaddr_q == A_SRCH_LEN && wval[15:0] != 16'h0) begin
        srch_len_q <= wval[15:0];
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q    <= S_IDLE;
      cnt_q      <= '0;
      exec_len_q <= '0;
      ORDER_BUSY <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            ORDER_BUSY <= 1'b1;
            state_q    <= wval[F_IND] ? S_IND : S_EXEC; // RQ19
            cnt_q      <= exec_cyc - CNT_W'(1);
            exec_len_q <= '0;
          end
        end
        S_IND: begin
          if (go_exec) begin
            state_q <= S_EXEC; // RQ19
            cnt_q   <= exec_cyc - CNT_W'(1);
          end
        end
        S_EXEC: begin
          exec_len_q <= exec_len_q + CNT_W'(1);
          cnt_q      <= cnt_q - CNT_W'(1); // RQ23
          if (fin) begin
            state_q    <= S_IDLE;
            ORDER_BUSY <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // Addressing and module choice
  // ****************************************
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ACCESS_ADDR   <= 15'h0;
      MEM_SECONDARY <= 1'b0;
      MEM_MODULE    <= 3'h0;
      prim_mod_q    <= 3'h0;
      sec_mod_q     <= 3'h0;
    end else if (start) begin
      ACCESS_ADDR   <= {3'h0, wval[11:0]};
      MEM_SECONDARY <= wval[F_MSEL]; // RQ20
      if (wval[F_REP]) begin
        // Designator replaces the module of the selected memory
        if (wval[F_MSEL]) begin
          sec_mod_q <= wval[F_MV +: 3]; // RQ21
        end else begin
          prim_mod_q <= wval[F_MV +: 3]; // RQ21
        end
        MEM_MODULE <= wval[F_MV +: 3]; // RQ21
      end else begin
        MEM_MODULE <= wval[F_MSEL] ? sec_mod_q : prim_mod_q; // RQ20
      end
    end else if (wr_go && awaddr_q == A_INDIRECT && state_q == S_IND) begin
      ACCESS_ADDR <= wval[14:0]; // RQ19
    end else if (wr_go && awaddr_q == A_MODULE && state_q == S_IDLE) begin
      prim_mod_q <= wval[2:0];
      sec_mod_q  <= wval[5:3];
    end
  end

  // ****************************************
  // Completion effects
  // ****************************************
  always_comb begin
    unique case (word_q[1:0])
      2'b00:   cond = ijf_q;
      2'b01:   cond = !ijf_q;
      2'b10:   cond = pin_q[0];
      default: cond = pin_q[1];
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      index_q <= 15'h0;
      ijf_q   <= 1'b0;
      taken_q <= 1'b0;
    end else if (fin) begin
      if (cls == C_SEARCH) begin
        ijf_q <= outcome_q[15]; // RQ5
        if (outcome_q[15]) begin
          index_q <= outcome_q[14:0]; // RQ5
        end
      end else if (cls == C_TEST) begin
        ijf_q <= outcome_q[15];
      end
      if (op == 6'o02) begin
        taken_q <= 1'b1; // RQ16
      end else if (op == 6'o03) begin
        taken_q <= cond; // RQ16
      end else if (op == 6'o27) begin
        taken_q <= outcome_q[15];
      end
    end
  end

  // ****************************************
  // AXI read channel
  // ****************************************
  always_comb begin
    rd_hit = 1'b1;
    unique case (ARVALID && ARREADY ? ARADDR : awaddr_q)
      A_ORDER:    rd_d = {7'h0, word_q};
      A_OUTCOME:  rd_d = {16'h0, outcome_q};
      A_SRCH_LEN: rd_d = {16'h0, srch_len_q};
      A_INDIRECT: rd_d = {17'h0, ACCESS_ADDR};
      A_STATUS:   rd_d = {14'h0, op, 4'(cls), 2'h0,
                          state_q == S_IND, par_err_q, taken_q,
                          pin_q[0], ijf_q, ORDER_BUSY};
      A_INDEX:    rd_d = {17'h0, index_q};
      A_MODULE:   rd_d = {26'h0, sec_mod_q, prim_mod_q};
      A_CYCLES:   rd_d = 32'(cnt_q);
      default: begin
        rd_d   = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b1;
      RDATA   <= rd_d;
      RRESP   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID  <= 1'b0;
      ARREADY <= 1'b1;
    end else if (!RVALID) begin
      ARREADY <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_add_store;
    fin && op == 6'o70 |-> exec_len_q == 24'd239;
  endproperty
  a_add_store: assert property (p_add_store) // RQ1
    else $error("add and store length wrong");

  property p_mul;
    fin && op == 6'o33 |-> exec_len_q == 24'd559;
  endproperty
  a_mul: assert property (p_mul) // RQ14
    else $error("multiply length wrong");

  property p_div;
    fin && op == 6'o32 |-> exec_len_q == 24'd1019;
  endproperty
  a_div: assert property (p_div) // RQ14
    else $error("divide length wrong");

  property p_nop;
    fin && cls == C_NOP |-> exec_len_q == 24'd79;
  endproperty
  a_nop: assert property (p_nop) // RQ24
    else $error("no-operation length wrong");

  // Busy length counted apart from the sequencer's own counter
  logic [15:0] busy_len_q;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      busy_len_q <= 16'h0;
    end else if (start) begin
      busy_len_q <= 16'h0;
    end else if (ORDER_BUSY) begin
      busy_len_q <= busy_len_q + 16'h1;
    end
  end

  property p_lit_test;
    $fell(ORDER_BUSY) && op == 6'o01 && !word_q[F_IND]
      |-> busy_len_q == 16'd80;
  endproperty
  a_lit_test: assert property (p_lit_test) // RQ6
    else $error("literal test not 4 us");

  property p_search;
    fin && cls == C_SEARCH && outcome_q[15]
      |=> ijf_q && index_q == $past(outcome_q[14:0]);
  endproperty
  a_search: assert property (p_search) // RQ5
    else $error("search hit not recorded");

  property p_miss;
    fin && cls == C_SEARCH && !outcome_q[15] |=> !ijf_q && $stable(index_q);
  endproperty
  a_miss: assert property (p_miss) // RQ5
    else $error("search miss changed state");

  property p_msel;
    start |=> MEM_SECONDARY == $past(wval[F_MSEL]) && ORDER_BUSY;
  endproperty
  a_msel: assert property (p_msel) // RQ20
    else $error("memory select wrong");

  property p_ind;
    state_q == S_IND && !go_exec |=> state_q == S_IND;
  endproperty
  a_ind: assert property (p_ind) // RQ19
    else $error("indirection ended early");

  property p_bresp;
    wr_go |=> BVALID;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write answer missing");

  c_search_hit: cover property (fin && cls == C_SEARCH && outcome_q[15]);
  c_indirect:   cover property (state_q == S_IND ##[1:40] go_exec);
  c_branch:     cover property (fin && op == 6'o03 && cond);
endmodule

// ---- tb/far_side_model.sv ----
// Behavioural model of the condition sources beyond the decoder
`timescale 1ns/1ns
module far_side_model (
  // Clock
  input  wire logic       CLK_SYS,
  // Requests from the bench
  input  wire logic       ext_req,
  input  wire logic       pc_req,
  input  wire logic [2:0] lag,
  // Condition pins
  output logic            EXT_JUMP,
  output logic            PROG_CTL
);
  logic [7:0] ext_hist_q = 8'h00;
  logic [7:0] pc_hist_q  = 8'h00;
  // ****************************************
  // Slow or prompt answer
  // ****************************************
  always @(posedge CLK_SYS) begin
    ext_hist_q <= {ext_hist_q[6:0], ext_req};
    pc_hist_q  <= {pc_hist_q[6:0], pc_req};
  end
  // Off the edge, since the pins are not timed to the decoder
  assign #7 EXT_JUMP = ext_hist_q[lag];
  assign #7 PROG_CTL = pc_hist_q[lag];
endmodule

// ---- tb/tb_order_code_decoder.sv ----
// Self-checking bench for the order code decoder
`timescale 1ns/1ns
module tb_order_code_decoder
  import order_decode_pkg::*;
;
  logic CLK_SYS = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, ext_req = 0, pc_req = 0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, rd, oc;
  logic [3:0] WSTRB = 4'hf;
  logic [2:0] lag = 3'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, ORDER_BUSY, MEM_SECONDARY;
  logic [1:0] BRESP, RRESP, rr, br;
  logic [31:0] RDATA;
  logic [2:0] MEM_MODULE;
  logic [14:0] ACCESS_ADDR, ei, a2;
  logic [17:0] lw;
  logic [5:0] op;
  wire EXT_JUMP, PROG_CTL;
  int fail_count = 0, cmp_count = 0, seed = 23298, busy_cyc = 0, k, m;

  order_code_decoder u_dut (.CLK_SYS(CLK_SYS), .RST(RST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .EXT_JUMP(EXT_JUMP), .PROG_CTL(PROG_CTL), .ORDER_BUSY(ORDER_BUSY),
    .MEM_SECONDARY(MEM_SECONDARY), .MEM_MODULE(MEM_MODULE),
    .ACCESS_ADDR(ACCESS_ADDR));
  far_side_model u_far (.CLK_SYS(CLK_SYS), .ext_req(ext_req),
    .pc_req(pc_req), .lag(lag), .EXT_JUMP(EXT_JUMP), .PROG_CTL(PROG_CTL));

  always #25 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) if (ORDER_BUSY === 1'b1) busy_cyc++;
  // ****************************************
  // Reporting
  // ****************************************
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic limit(input int n);
    if (n > 3000) begin
      fail_count++;
      $display("Error at %0t: wait limit reached", $time);
      give_verdict();
    end
  endtask
  // ****************************************
  // Register bus
  // ****************************************
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      limit(++n);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    br = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK_SYS);
      limit(++n);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rd = RDATA;
    rr = RRESP;
    RREADY <= 1'b0;
  endtask
  // ****************************************
  // Orders and expectations
  // ****************************************
  function automatic logic [31:0] word(input logic [5:0] o,
                                       input logic [17:0] l);
    return {7'h0, ~^{o, l}, o, l};
  endfunction
  function automatic int exp_us(input logic [5:0] o, input logic hit,
                                input int mm);
    case (o)
      6'h38, 6'h39, 6'h3d, 6'h33, 6'h3f, 6'h3a, 6'h3b, 6'h3e, 6'h2d,
      6'h37: return 12;
      6'h11, 6'h15, 6'h14, 6'h1d, 6'h1c, 6'h25, 6'h1e, 6'h1f, 6'h20,
      6'h17, 6'h21, 6'h12, 6'h36, 6'h18, 6'h19: return 8;
      6'h1b: return 28;
      6'h1a: return 51;
      6'h31, 6'h35, 6'h34: return (hit ? 16 : 12) + 8 * (mm - 1);
      default: return 4;
    endcase
  endfunction
  task automatic wait_idle();
    int n;
    n = 0;
    while (ORDER_BUSY === 1'b1) begin
      @(posedge CLK_SYS);
      limit(++n);
    end
  endtask
  // A second order while busy must not lengthen the first
  task automatic run_order(input logic [31:0] w, input int us,
                           input logic extra);
    busy_cyc = 0;
    axi_write(A_ORDER, w);
    if (extra) axi_write(A_ORDER, word(6'h38, 18'h0));
    wait_idle();
    check(32'(busy_cyc), 32'(us * CYC_PER_US));
  endtask
  task automatic taken_is(input logic exp);
    axi_read(A_STATUS);
    check(32'(rd[3]), 32'(exp));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    ei = 15'h0;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    axi_read(A_SRCH_LEN);
    check(rd, 32'(SRCH_LEN_RST));
    axi_read(8'h20);
    check({rd[29:0], rr}, {30'h0, RESP_SLVERR});
    axi_write(8'h20, 32'h0);
    check(32'(br), 32'(RESP_SLVERR));
    $display("Reset and map test done");
    for (k = 0; k < 64; k++) begin
      op = 6'(k);
      m = ($random(seed) & 3) + 1;
      oc = $random(seed) & 32'hffff;
      lw = 18'($random(seed)) & 18'h3bfff;
      axi_write(A_SRCH_LEN, 32'(m));
      axi_write(A_OUTCOME, oc);
      run_order(word(op, lw), exp_us(op, oc[15], m), 1'b0);
      check(32'(MEM_SECONDARY), 32'(lw[12]));
      if (op inside {6'h31, 6'h35, 6'h34, 6'h01, 6'h05, 6'h04, 6'h11,
                     6'h15, 6'h14}) begin
        axi_read(A_STATUS);
        check(32'(rd[1]), 32'(oc[15]));
      end
      if (op inside {6'h31, 6'h35, 6'h34}) begin
        if (oc[15]) ei = oc[14:0];
        axi_read(A_INDEX);
        check({17'h0, rd[14:0]}, {17'h0, ei});
      end
    end
    run_order(word(6'h1a, 18'h0), 51, 1'b1);
    $display("Order timing test done");
    ext_req <= 1'b1;
    lag <= 3'h7;
    axi_write(A_OUTCOME, 32'h8000);
    run_order(word(6'h01, 18'h0), 4, 1'b0);
    for (k = 0; k < 8; k++) begin
      pc_req <= k[2];
      run_order(word(6'h03, 18'(k)), 4, 1'b0);
      taken_is(k[1:0] == 2'd1 ? 1'b0 : (k[1:0] != 2'd3 || k[2]));
    end
    check(32'(rd[2]), 32'h1);
    axi_write(A_OUTCOME, 32'h0);
    run_order(word(6'h17, 18'h0), 8, 1'b0);
    taken_is(1'b0);
    run_order(word(6'h02, 18'h0), 4, 1'b0);
    taken_is(1'b1);
    $display("Branch test done");
    axi_write(A_MODULE, 32'h2a);
    run_order(word(6'h1e, 18'h1000), 8, 1'b0);
    check(32'(MEM_MODULE), 32'h5);
    run_order(word(6'h1e, 18'h2c00), 8, 1'b0);
    check(32'(MEM_MODULE), 32'h6);
    axi_read(A_MODULE);
    check(32'(rd[5:0]), 32'h2e);
    $display("Module test done");
    a2 = 15'($random(seed));
    axi_write(A_ORDER, word(6'h1e, 18'h4000));
    axi_write(A_INDIRECT, 32'h8123);
    axi_read(A_STATUS);
    check(32'(rd[5]), 32'h1);
    axi_write(A_INDIRECT, {17'h0, a2});
    wait_idle();
    check(32'(ACCESS_ADDR), 32'(a2));
    $display("Indirect test done");
    give_verdict();
  end
endmodule
